// File: rtl/sste_exec_top.sv
// Purpose: execution slice for subtract, nibble swap and direction load
// Assumes: decoder offers one instruction per cycle; file read is combinational
// Notes: file writes and all results appear one edge after the instruction
//
// Summary of operation
// RULE1: subtract work register from addressed file register
// RULE2: destination bit picks work or file register
// RULE3: carry and digit carry mean no borrow
// RULE4: zero result sets zero and carry flags
// RULE5: swap nibbles of operand, flags untouched
// RULE6: swap result to file or work register
// RULE7: direction load copies work into selected register
// RULE8: direction registers also reachable by file address
// RULE9: one word, one cycle, commit at cycle end
`timescale 1ns/1ps
`default_nettype none
module sste_exec_top (
  input wire logic ref_clk,
  input wire logic rst,
  // instruction side
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  output logic instr_ready,
  // register file side
  output logic [6:0] file_raddr,
  input wire logic [7:0] file_rdata,
  output logic file_we,
  output logic [6:0] file_waddr,
  output logic [7:0] file_wdata,
  // core state
  output logic [7:0] work_reg,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic [7:0] port_dir_5,
  output logic [7:0] port_dir_6,
  output logic [7:0] port_dir_7,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  sste_pkg::sste_state_t s_r;
  sste_pkg::sste_state_t s_nxt;

  logic take;
  logic is_sub;
  logic is_swap;
  logic is_dirld;
  logic dbit;
  logic [6:0] faddr;
  logic dir_hit;
  logic [1:0] dir_idx;
  logic [7:0] operand;
  logic [3:0] op_lo;
  logic [3:0] op_hi;
  logic [3:0] work_lo;
  logic [7:0] sub_res;
  logic sub_carry;
  logic sub_digit;
  logic sub_zero;
  logic [7:0] swap_res;
  logic [7:0] alu_res;
  logic dirld_ok;
  logic [1:0] dirld_idx;
  logic bus_take;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic faddr_is_dir(input logic [6:0] a);
    faddr_is_dir = (a >= sste_pkg::DIR_FADDR_BASE) && (a <= sste_pkg::DIR_FADDR_LAST);
  endfunction : faddr_is_dir

  function automatic logic [1:0] faddr_dir_idx(input logic [6:0] a);
    logic [6:0] off;
    off = a - sste_pkg::DIR_FADDR_BASE;
    faddr_dir_idx = off[1:0];
  endfunction : faddr_dir_idx

  function automatic logic [31:0] read_mux(input sste_pkg::sste_state_t st,
                                           input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      sste_pkg::REG_WORK: v[7:0] = st.work;
      sste_pkg::REG_FLAGS:
      begin
        v[sste_pkg::FLAG_CARRY_POS] = st.carry;
        v[sste_pkg::FLAG_DIGIT_POS] = st.digit_carry;
        v[sste_pkg::FLAG_ZERO_POS] = st.zero;
      end
      sste_pkg::REG_DIR5: v[7:0] = st.dir[0];
      sste_pkg::REG_DIR6: v[7:0] = st.dir[1];
      sste_pkg::REG_DIR7: v[7:0] = st.dir[2];
      sste_pkg::REG_CTRL: v[sste_pkg::CTRL_EXEC_EN_POS] = st.exec_en;
      sste_pkg::REG_COUNT: v[15:0] = st.count;
      default: v = 32'h0000_0000;
    endcase
    read_mux = v;
  endfunction : read_mux

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode and operand fetch

  assign instr_ready = s_r.exec_en;
  assign take = instr_valid && s_r.exec_en;
  assign is_sub = (instr_word[13:8] == sste_pkg::OPC_SUB_W_FROM_FILE);
  assign is_swap = (instr_word[13:8] == sste_pkg::OPC_NIBBLE_SWAP);
  assign is_dirld = (instr_word[13:3] == sste_pkg::OPC_PORT_DIR_LOAD);
  assign dbit = instr_word[sste_pkg::DBIT_POS];
  assign faddr = instr_word[6:0]; // see RULE1
  assign file_raddr = faddr;
  assign dir_hit = faddr_is_dir(faddr);
  assign dir_idx = faddr_dir_idx(faddr);
  // direction registers live here, so their operand comes from s_r.dir, not file_rdata
  assign operand = dir_hit ? s_r.dir[dir_idx] : file_rdata; // see RULE8
  assign op_lo = operand[3:0];
  assign op_hi = operand[7:4];
  assign work_lo = s_r.work[3:0];
  // selector outside 5..7 makes the direction load a no-op
  assign dirld_ok = (instr_word[2:0] >= sste_pkg::DIR_SEL_FIRST); // see RULE7
  assign dirld_idx = 2'(instr_word[2:0] - sste_pkg::DIR_SEL_FIRST);
  assign alu_res = is_sub ? sub_res : swap_res;

  sste_alu u_alu (
    .operand(operand),
    .work(s_r.work),
    .sub_res(sub_res),
    .sub_carry(sub_carry),
    .sub_digit(sub_digit),
    .sub_zero(sub_zero),
    .swap_res(swap_res)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus address phase: zero wait states, always OKAY

  assign bus_take = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.f_we = 1'b0;
    s_nxt.dph_wr = bus_take && hwrite && (hsize == sste_pkg::HSIZE_WORD);
    s_nxt.dph_addr = haddr[7:0];
    if (bus_take && !hwrite)
    begin
      s_nxt.hrdata = read_mux(s_r, haddr[7:0]);
    end
    // bus data phase first, so a same-cycle instruction overrides it
    if (s_r.dph_wr)
    begin
      case (s_r.dph_addr)
        sste_pkg::REG_WORK: s_nxt.work = hwdata[7:0];
        sste_pkg::REG_FLAGS:
        begin
          s_nxt.carry = hwdata[sste_pkg::FLAG_CARRY_POS];
          s_nxt.digit_carry = hwdata[sste_pkg::FLAG_DIGIT_POS];
          s_nxt.zero = hwdata[sste_pkg::FLAG_ZERO_POS];
        end
        sste_pkg::REG_DIR5: s_nxt.dir[0] = hwdata[7:0];
        sste_pkg::REG_DIR6: s_nxt.dir[1] = hwdata[7:0];
        sste_pkg::REG_DIR7: s_nxt.dir[2] = hwdata[7:0];
        sste_pkg::REG_CTRL: s_nxt.exec_en = hwdata[sste_pkg::CTRL_EXEC_EN_POS];
        default: s_nxt.exec_en = s_nxt.exec_en;
      endcase
    end
    if (take && (is_sub || is_swap || is_dirld))
    begin
      s_nxt.count = s_r.count + 16'h0001; // see RULE9
    end
    if (take && (is_sub || is_swap))
    begin
      if (!dbit)
      begin
        s_nxt.work = alu_res; // see RULE2 see RULE6
      end
      else if (dir_hit)
      begin
        s_nxt.dir[dir_idx] = alu_res; // see RULE8
      end
      else
      begin
        s_nxt.f_we = 1'b1; // see RULE2 see RULE6
        s_nxt.f_waddr = faddr;
        s_nxt.f_wdata = alu_res;
      end
      if (is_sub)
      begin
        s_nxt.carry = sub_carry; // see RULE3
        s_nxt.digit_carry = sub_digit; // see RULE3
        s_nxt.zero = sub_zero; // see RULE4
      end
    end
    if (take && is_dirld && dirld_ok)
    begin
      s_nxt.dir[dirld_idx] = s_r.work; // see RULE7
    end
    if (rst)
    begin
      s_nxt = '0;
      s_nxt.work = sste_pkg::RST_WORK;
      s_nxt.exec_en = sste_pkg::RST_EXEC_EN;
      for (int i = 0; i < sste_pkg::DIR_COUNT; i++)
      begin
        s_nxt.dir[i] = sste_pkg::RST_DIR;
      end
    end
  end

  // results commit together at the edge closing the instruction cycle
  always_ff @(posedge ref_clk)
  begin
    s_r <= s_nxt; // see RULE9
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign file_we = s_r.f_we;
  assign file_waddr = s_r.f_waddr;
  assign file_wdata = s_r.f_wdata;
  assign work_reg = s_r.work;
  assign carry_flag = s_r.carry;
  assign digit_carry_flag = s_r.digit_carry;
  assign zero_flag = s_r.zero;
  assign port_dir_5 = s_r.dir[0];
  assign port_dir_6 = s_r.dir[1];
  assign port_dir_7 = s_r.dir[2];
  assign hrdata = s_r.hrdata;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence sub_taken;
    take && is_sub;
  endsequence

  sequence swap_taken;
    take && is_swap;
  endsequence

  a_sub_to_work: assert property ( // see RULE1
    sub_taken and (!dbit) |=> work_reg == $past(operand) - $past(work_reg))
    else $error("subtract result to work register wrong");

  a_sub_to_file: assert property ( // see RULE2
    sub_taken and (dbit && !dir_hit) |=>
      file_we && file_waddr == $past(faddr) &&
      file_wdata == $past(operand) - $past(work_reg) ##1 !file_we || $past(take))
    else $error("subtract write-back to file wrong");

  a_sub_carry_flags: assert property ( // see RULE3
    sub_taken |=> carry_flag == ($past(operand) >= $past(work_reg)) &&
      digit_carry_flag == ($past(op_lo) >= $past(work_lo)))
    else $error("carry or digit carry wrong after subtract");

  a_sub_zero_flag: assert property ( // see RULE4
    sub_taken |=> zero_flag == ($past(operand) == $past(work_reg)) &&
      (!zero_flag || carry_flag))
    else $error("zero flag wrong after subtract");

  a_swap_flags_hold: assert property ( // see RULE5
    swap_taken |=> $stable({carry_flag, digit_carry_flag, zero_flag}))
    else $error("nibble swap changed a flag");

  a_swap_to_work: assert property ( // see RULE6
    swap_taken and (!dbit) |=> work_reg == {$past(op_lo), $past(op_hi)} && !file_we)
    else $error("nibble swap to work register wrong");

  a_dirload_copy: assert property ( // see RULE7
    take && is_dirld && instr_word[2:0] == 3'h6 |=>
      port_dir_6 == $past(work_reg) &&
      $stable({carry_flag, digit_carry_flag, zero_flag}))
    else $error("direction load did not copy work register");

  a_dir_file_write: assert property ( // see RULE8
    take && (is_sub || is_swap) && dbit && faddr == 7'h65 |=>
      !file_we && port_dir_5 == $past(alu_res))
    else $error("direction register write leaked to file");

  a_one_cycle_count: assert property ( // see RULE9
    take && (is_sub || is_swap || is_dirld) |=>
      s_r.count == $past(s_r.count) + 16'h0001)
    else $error("instruction not completed in one cycle");

endmodule : sste_exec_top
`default_nettype wire

// File: rtl/sste_pkg.sv
// Purpose: shared constants for the subtract / nibble swap / direction load slice
// Assumes: 8-bit data path, 14-bit instruction word, 7-bit file address
// Notes: bus offsets are byte addresses of 32-bit aligned words
package sste_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // instruction word fields and opcodes
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned DBIT_POS = 7;
  localparam logic [5:0] OPC_SUB_W_FROM_FILE = 6'h02;
  localparam logic [5:0] OPC_NIBBLE_SWAP = 6'h0E;
  localparam logic [10:0] OPC_PORT_DIR_LOAD = 11'h00C;
  localparam logic [2:0] DIR_SEL_FIRST = 3'h5;
  localparam logic [2:0] DIR_SEL_LAST = 3'h7;
  localparam int unsigned DIR_COUNT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // file addresses at which the direction registers are reached directly
  localparam logic [6:0] DIR_FADDR_BASE = 7'h65;
  localparam logic [6:0] DIR_FADDR_LAST = 7'h67;

  ////////////////////////////////////////////////////////////////////////////
  // bus register map
  localparam logic [7:0] REG_WORK = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_DIR5 = 8'h08;
  localparam logic [7:0] REG_DIR6 = 8'h0C;
  localparam logic [7:0] REG_DIR7 = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  localparam logic [7:0] REG_COUNT = 8'h18;
  localparam int unsigned FLAG_CARRY_POS = 0;
  localparam int unsigned FLAG_DIGIT_POS = 1;
  localparam int unsigned FLAG_ZERO_POS = 2;
  localparam int unsigned CTRL_EXEC_EN_POS = 0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_WORK = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic RST_EXEC_EN = 1'b1;

  typedef struct packed {
    logic [7:0] work;
    logic carry;
    logic digit_carry;
    logic zero;
    logic [2:0][7:0] dir;
    logic exec_en;
    logic [15:0] count;
    logic f_we;
    logic [6:0] f_waddr;
    logic [7:0] f_wdata;
    logic [31:0] hrdata;
    logic dph_wr;
    logic [7:0] dph_addr;
  } sste_state_t;

endpackage : sste_pkg

// File: rtl/sste_alu.sv
// Purpose: arithmetic for the slice: file minus work, and nibble exchange
// Assumes: operands valid in the same cycle; pure combinational
// Notes: carry and digit carry are no-borrow indications
`timescale 1ns/1ps
`default_nettype none
module sste_alu (
  input wire logic [7:0] operand,
  input wire logic [7:0] work,
  output logic [7:0] sub_res,
  output logic sub_carry,
  output logic sub_digit,
  output logic sub_zero,
  output logic [7:0] swap_res
);

  logic [8:0] diff;
  logic [4:0] diff_lo;

  ////////////////////////////////////////////////////////////////////////////
  // nine bits so the borrow falls out of the top bit
  assign diff = {1'b0, operand} - {1'b0, work}; // see RULE1
  assign diff_lo = {1'b0, operand[3:0]} - {1'b0, work[3:0]};
  assign sub_res = diff[7:0]; // see RULE1
  assign sub_carry = ~diff[8]; // see RULE3
  assign sub_digit = ~diff_lo[4]; // see RULE3
  // a zero result never borrows, so carry is set with it
  assign sub_zero = (diff[7:0] == 8'h00); // see RULE4
  assign swap_res = {operand[3:0], operand[7:4]}; // see RULE5

endmodule : sste_alu
`default_nettype wire

// File: bench/sste_file_model.sv
// Purpose: register file partner that supplies operands and takes results
// Assumes: read is combinational, a write lands at the rising edge
// Notes: contents start from a fixed pattern that the bench mirrors
`timescale 1ns/1ps
`default_nettype none
module sste_file_model (
  input wire logic clk,
  input wire logic [6:0] raddr,
  output logic [7:0] rdata,
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata
);
  logic [7:0] mem [128];
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i * 37);
  end
  assign rdata = mem[raddr];
  always @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end
endmodule : sste_file_model
`default_nettype wire

// File: bench/tb.sv
// Purpose: random and corner tests of the execution slice
// Assumes: zero-wait bus slave, results visible just after the taking edge
// Notes: shadow copies of work, flags, direction and file contents
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk, rst, instr_valid, instr_ready, file_we, hsel, hwrite;
  logic [13:0] instr_word;
  logic [6:0] file_raddr, file_waddr;
  logic [7:0] file_rdata, file_wdata, work_reg, port_dir_5, port_dir_6, port_dir_7;
  logic carry_flag, digit_carry_flag, zero_flag, hreadyout, hresp, en;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, ef;
  logic [7:0] mem [128];
  logic [7:0] ed [3];
  logic [7:0] ew, op, r;
  int n_fail, num_checks, cyc, n_ins;

  sste_exec_top DUT (.ref_clk, .rst, .instr_valid, .instr_word, .instr_ready,
    .file_raddr, .file_rdata, .file_we, .file_waddr, .file_wdata, .work_reg,
    .carry_flag, .digit_carry_flag, .zero_flag, .port_dir_5, .port_dir_6,
    .port_dir_7, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata);
  sste_file_model fm (.clk(ref_clk), .raddr(file_raddr), .rdata(file_rdata),
    .we(file_we), .waddr(file_waddr), .wdata(file_wdata));

  initial
  begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      final_report();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // flags after file minus work, ordered {zero, digit carry, carry}
  function automatic logic [2:0] exp_flags(input logic [7:0] a, input logic [7:0] b);
    exp_flags = {a == b, a[3:0] >= b[3:0], a >= b};
  endfunction : exp_flags

  function automatic logic [7:0] exp_swap(input logic [7:0] a);
    exp_swap = {a[3:0], a[7:4]};
  endfunction : exp_swap

  // idle cycle first, so a read never meets the write just before it
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask : ahb

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'h0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rchk

  task automatic exec(input logic [13:0] w);
    logic [6:0] f;
    logic dr, we, alu;
    f = w[6:0];
    dr = f >= sste_pkg::DIR_FADDR_BASE && f <= sste_pkg::DIR_FADDR_LAST;
    op = dr ? ed[f - sste_pkg::DIR_FADDR_BASE] : mem[f];
    we = 1'h0;
    alu = 1'h0;
    // recognised words count even when a direction load selector is out of range
    if (en && (w[13:8] == sste_pkg::OPC_SUB_W_FROM_FILE || w[13:8] == sste_pkg::OPC_NIBBLE_SWAP
        || w[13:3] == sste_pkg::OPC_PORT_DIR_LOAD))
      n_ins++;
    if (en && w[13:8] == sste_pkg::OPC_SUB_W_FROM_FILE)
    begin
      alu = 1'h1;
      r = op - ew;
      ef = exp_flags(op, ew);
    end
    else if (en && w[13:8] == sste_pkg::OPC_NIBBLE_SWAP)
    begin
      alu = 1'h1;
      r = exp_swap(op);
    end
    else if (en && w[13:3] == sste_pkg::OPC_PORT_DIR_LOAD && w[2:0] >= 3'h5)
      ed[w[2:0] - 3'h5] = ew;
    if (alu && !w[7])
      ew = r;
    else if (alu && dr)
      ed[f - sste_pkg::DIR_FADDR_BASE] = r;
    else if (alu)
    begin
      we = 1'h1;
      mem[f] = r;
    end
    @(posedge ref_clk);
    instr_valid <= 1'h1;
    instr_word <= w;
    @(posedge ref_clk);
    instr_valid <= 1'h0;
    #1;
    chk("ready", 32'(instr_ready), 32'(en));
    chk("file_we", 32'(file_we), 32'(we));
    if (we)
      chk("file_wr", {17'h0, file_waddr, file_wdata}, {17'h0, f, r});
    chk("work", 32'(work_reg), 32'(ew));
    chk("flags", {29'h0, zero_flag, digit_carry_flag, carry_flag}, 32'(ef));
    chk("dirs", {8'h0, port_dir_5, port_dir_6, port_dir_7}, {8'h0, ed[0], ed[1], ed[2]});
  endtask : exec

  task automatic setw(input logic [7:0] v);
    ahb(1'h1, sste_pkg::REG_WORK, {24'h0, v});
    ew = v;
  endtask : setw

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'h1;
    instr_valid = 1'h0;
    instr_word = 14'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = sste_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i * 37);
    ew = sste_pkg::RST_WORK;
    ef = 3'h0;
    ed = '{3{sste_pkg::RST_DIR}};
    en = 1'h1;
    void'($urandom(82625));
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    rchk("dir7", sste_pkg::REG_DIR7, 32'hFF);
    rchk("hole", 8'h1C, 32'h0);
    setw(mem[7'h20]);
    exec({sste_pkg::OPC_SUB_W_FROM_FILE, 1'h0, 7'h20});
    setw(mem[7'h7F] + 8'h1);
    exec({sste_pkg::OPC_SUB_W_FROM_FILE, 1'h1, 7'h7F});
    setw(8'h0F);
    exec({sste_pkg::OPC_SUB_W_FROM_FILE, 1'h1, 7'h00});
    ahb(1'h1, sste_pkg::REG_FLAGS, 32'h7);
    ef = 3'h7;
    exec({sste_pkg::OPC_NIBBLE_SWAP, 1'h0, 7'h7F});
    exec({sste_pkg::OPC_NIBBLE_SWAP, 1'h1, 7'h00});
    exec({sste_pkg::OPC_NIBBLE_SWAP, 1'h1, 7'h66});
    // a swap of 0xFF shows nothing, so give one direction register a real pattern
    ahb(1'h1, sste_pkg::REG_DIR5, 32'h3C);
    ed[0] = 8'h3C;
    exec({sste_pkg::OPC_NIBBLE_SWAP, 1'h1, 7'h65});
    exec({sste_pkg::OPC_SUB_W_FROM_FILE, 1'h0, 7'h67});
    for (int s = 0; s < 8; s++)
      exec({sste_pkg::OPC_PORT_DIR_LOAD, 3'(s)});
    ahb(1'h1, sste_pkg::REG_CTRL, 32'h0);
    en = 1'h0;
    exec({sste_pkg::OPC_SUB_W_FROM_FILE, 1'h1, 7'h10});
    ahb(1'h1, sste_pkg::REG_CTRL, 32'h1);
    en = 1'h1;
    // random mix of the three operations with fresh work values
    repeat (80)
    begin
      case ($urandom % 4)
        0: setw(8'($urandom));
        1: exec({sste_pkg::OPC_SUB_W_FROM_FILE, 8'($urandom)});
        2: exec({sste_pkg::OPC_NIBBLE_SWAP, 8'($urandom)});
        default: exec({sste_pkg::OPC_PORT_DIR_LOAD, 3'h5 + 3'($urandom % 3)});
      endcase
    end
    rchk("flag_reg", sste_pkg::REG_FLAGS, {29'h0, ef});
    rchk("dir5", sste_pkg::REG_DIR5, {24'h0, ed[0]});
    rchk("count", sste_pkg::REG_COUNT, 32'(n_ins));
    rchk("ctrl", sste_pkg::REG_CTRL, 32'h1);
    // second reset in mid-run: all state must fall back to its reset values
    @(posedge ref_clk);
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    #1;
    chk("work_rst", 32'(work_reg), 32'(sste_pkg::RST_WORK));
    chk("flags_rst", {29'h0, zero_flag, digit_carry_flag, carry_flag}, 32'h0);
    chk("dirs_rst", {8'h0, port_dir_5, port_dir_6, port_dir_7}, {8'h0, {3{sste_pkg::RST_DIR}}});
    rchk("count_rst", sste_pkg::REG_COUNT, 32'h0);
    final_report();
  end
endmodule : tb
`default_nettype wire
